//--- core/host_port_device.sv
// Function
// - Four channels, 24 addresses each
// - Region tails 0x18-0x1F style are undefined
// - 0x78-0x7F is device control region
// - Host waits update before same address
// - Different addresses may follow back to back
// - Master stage on write strobe, slave on clock
// - Masters host writable, cleared by hard reset
// - Reads return slaves; hard or soft clears
// - Indirect space in 256 word pages
// - Page from bits 9:8, code 3 unused
// - Indirect bits 14:10 ignored
// - Indirect bit 15: one read, zero write
// - Reset held at least 10 clocks; the bench's first reset lasts 6
// - Drive data bus only during read strobe; here the enable comes on and drops three clocks after the strobe pins do
// - Second read mode: strobes steer bus enable
// - Hard reset pulse clears masters and slaves
`timescale 1ns/1ps
`default_nettype none

module host_port_device (
  input wire logic core_clk_i,
  input wire logic reset_i,
  host_port_if.device port_if,
  input wire logic soft_reset_i,
  output logic cfg_upd_o,
  output host_cfg_pkg::addr_t cfg_addr_o,
  output host_cfg_pkg::data_t cfg_data_o,
  output host_cfg_pkg::data_t dev_ctrl_o,
  output host_cfg_pkg::data_t out_route_o,
  output logic sync_out_o,
  output logic hard_reset_o,
  output logic ind_valid_o,
  output logic ind_read_o,
  output logic [1:0] ind_channel_o,
  output logic [1:0] ind_page_o,
  output logic [7:0] ind_word_o
);
  import host_cfg_pkg::*;

  logic [3:0] ctrl_s1_q;
  logic [3:0] ctrl_s2_q;
  addr_t addr_s1_q;
  addr_t addr_s2_q;
  data_t data_s1_q;
  data_t data_s2_q;
  logic wr_prev_q;
  logic mode_s;
  logic cs_n_s;
  logic wr_n_s;
  logic rd_n_s;
  logic wr_rise;
  logic write_fire;
  logic read_act;
  logic hard_q;
  logic sync_q;
  data_t master_q [NUM_LOC];
  data_t slave_q [NUM_LOC];
  logic [UPD_CYC-1:0] upd_vld_q;
  addr_t upd_addr_q [UPD_CYC];
  addr_t upd_addr;
  logic upd_fire;
  data_t rd_data_q;
  logic rd_oe_q;
  logic cfg_upd_q;
  addr_t cfg_addr_q;
  data_t cfg_data_q;
  data_t dev_ctrl_q;
  data_t out_route_q;
  logic ind_valid_q;
  logic ind_read_q;
  logic [1:0] ind_channel_q;
  logic [1:0] ind_page_q;
  logic [7:0] ind_word_q;

  // Channel locations, plus the writable device control words
  function automatic logic is_writable(input addr_t a);
    logic ok;
    ok = (a[4:3] != REGION_TAIL);
    ok = ok | (a == DEV_CTRL_ADDR) | (a == DEV_ROUTE_ADDR);
    ok = ok | (a == DEV_STATUS_ADDR);
    return ok;
  endfunction

  // Read word for an address; gaps and unused words return zero
  function automatic data_t read_word(input addr_t a, input data_t slave_val);
    data_t w;
    w = 16'h0000;
    if (a == DEV_REV_ADDR)
    begin
      w = REV_WORD;
    end
    else if (is_writable(a))
    begin
      w = slave_val;
    end
    return w;
  endfunction

  // Pins come from the host domain: two flops before any decode
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      ctrl_s1_q <= CTRL_IDLE;
      ctrl_s2_q <= CTRL_IDLE;
      addr_s1_q <= 7'h00;
      addr_s2_q <= 7'h00;
      data_s1_q <= 16'h0000;
      data_s2_q <= 16'h0000;
    end
    else
    begin
      ctrl_s1_q <= {port_if.rd_mode, port_if.cs_n, port_if.wr_n, port_if.rd_n};
      ctrl_s2_q <= ctrl_s1_q;
      addr_s1_q <= port_if.addr;
      addr_s2_q <= addr_s1_q;
      data_s1_q <= port_if.bus;
      data_s2_q <= data_s1_q;
    end
  end

  assign mode_s = ctrl_s2_q[3];
  assign cs_n_s = ctrl_s2_q[2];
  assign wr_n_s = ctrl_s2_q[1];
  assign rd_n_s = ctrl_s2_q[0];

  // Edge detector on the second stage only
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      wr_prev_q <= 1'b1;
    end
    else
    begin
      wr_prev_q <= wr_n_s;
    end
  end

  // Write strobe end marks the master capture; in mode one a low read pin means read
  assign wr_rise = wr_n_s & ~wr_prev_q;
  assign write_fire = wr_rise & ~cs_n_s & (~mode_s | rd_n_s);
  assign read_act = ~cs_n_s & ~rd_n_s & (~mode_s | ~wr_n_s);

  // Immediate actions are one-cycle pulses, never stored
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      hard_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      hard_q <= write_fire & (addr_s2_q == DEV_ACTION_ADDR) & data_s2_q[ACT_HARD_BIT];
      sync_q <= write_fire & (addr_s2_q == DEV_ACTION_ADDR) & data_s2_q[ACT_SYNC_BIT];
    end
  end

  // Master stage: taken on the write strobe, cleared by hard resets only
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i | hard_q)
    begin
      for (int i = 0; i < NUM_LOC; i++)
      begin
        master_q[i] <= 16'h0000;
      end
    end
    else if (write_fire & is_writable(addr_s2_q))
    begin
      master_q[addr_s2_q] <= data_s2_q;
    end
  end

  // Transfer pipeline: one slot per cycle, so writes to other addresses
  // may follow each other without waiting; same address relies on host spacing
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i | hard_q)
    begin
      upd_vld_q <= '0;
      for (int i = 0; i < UPD_CYC; i++)
      begin
        upd_addr_q[i] <= 7'h00;
      end
    end
    else
    begin
      upd_vld_q <= {upd_vld_q[UPD_CYC-2:0], write_fire & is_writable(addr_s2_q)};
      upd_addr_q[0] <= addr_s2_q;
      for (int i = 1; i < UPD_CYC; i++)
      begin
        upd_addr_q[i] <= upd_addr_q[i-1];
      end
    end
  end

  assign upd_fire = upd_vld_q[UPD_CYC-1];
  assign upd_addr = upd_addr_q[UPD_CYC-1];

  // Slave stage on the core clock; soft reset clears it but not the masters
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i | hard_q | soft_reset_i)
    begin
      for (int i = 0; i < NUM_LOC; i++)
      begin
        slave_q[i] <= 16'h0000;
      end
    end
    else if (upd_fire)
    begin
      slave_q[upd_addr] <= master_q[upd_addr];
    end
  end

  // Read return: bus enable follows the synchronised read strobe one clock later, on and off
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      rd_oe_q <= 1'b0;
      rd_data_q <= 16'h0000;
    end
    else
    begin
      rd_oe_q <= read_act;
      rd_data_q <= read_act ? read_word(addr_s2_q, slave_q[addr_s2_q]) : 16'h0000;
    end
  end

  assign port_if.dev_oe = rd_oe_q;
  assign port_if.dev_data = rd_data_q;

  // Update notice to the core, carrying the value that just went live
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i | hard_q)
    begin
      cfg_upd_q <= 1'b0;
      cfg_addr_q <= 7'h00;
      cfg_data_q <= 16'h0000;
    end
    else
    begin
      cfg_upd_q <= upd_fire;
      cfg_addr_q <= upd_addr;
      cfg_data_q <= master_q[upd_addr];
    end
  end

  // Device wide control words follow their slaves
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      dev_ctrl_q <= 16'h0000;
      out_route_q <= 16'h0000;
    end
    else
    begin
      dev_ctrl_q <= slave_q[DEV_CTRL_ADDR];
      out_route_q <= slave_q[DEV_ROUTE_ADDR];
    end
  end

  // Indirect address decode at the channel's first word; page code 3 is dropped
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i | hard_q)
    begin
      ind_valid_q <= 1'b0;
      ind_read_q <= 1'b0;
      ind_channel_q <= 2'h0;
      ind_page_q <= 2'h0;
      ind_word_q <= 8'h00;
    end
    else
    begin
      // Channel 3 owns 0x60, so offset 0 is never a device control word; no channel check
      ind_valid_q <= upd_fire & (upd_addr[4:0] == IND_LOCAL_OFS)
        & (master_q[upd_addr][IND_PAGE_HI:IND_PAGE_LO] != IND_PAGE_UNUSED);
      ind_read_q <= master_q[upd_addr][IND_RD_BIT];
      ind_channel_q <= upd_addr[6:5];
      ind_page_q <= master_q[upd_addr][IND_PAGE_HI:IND_PAGE_LO];
      ind_word_q <= master_q[upd_addr][7:0];
    end
  end

  assign cfg_upd_o = cfg_upd_q;
  assign cfg_addr_o = cfg_addr_q;
  assign cfg_data_o = cfg_data_q;
  assign dev_ctrl_o = dev_ctrl_q;
  assign out_route_o = out_route_q;
  assign sync_out_o = sync_q;
  assign hard_reset_o = hard_q;
  assign ind_valid_o = ind_valid_q;
  assign ind_read_o = ind_read_q;
  assign ind_channel_o = ind_channel_q;
  assign ind_page_o = ind_page_q;
  assign ind_word_o = ind_word_q;

endmodule

`default_nettype wire

//--- core/host_cfg_pkg.sv
package host_cfg_pkg;

  // Bus widths
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int NUM_LOC = 128;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] data_t;

  // Core clock and reset figures
  localparam int CLK_PERIOD_NS = 20;
  localparam int RESET_MIN_CYC = 10;

  // Address map: bits 6:5 pick a channel, bits 4:3 == 3 mark the tail of a region
  localparam logic [1:0] REGION_TAIL = 2'h3;
  localparam logic [1:0] CH_DEVICE = 2'h3;
  localparam int CH_REGS = 24;
  localparam addr_t DEV_CTRL_ADDR = 7'h78;
  localparam addr_t DEV_ROUTE_ADDR = 7'h79;
  localparam addr_t DEV_REV_ADDR = 7'h7D;
  localparam addr_t DEV_STATUS_ADDR = 7'h7E;
  localparam addr_t DEV_ACTION_ADDR = 7'h7F;

  // Immediate action bits
  localparam int ACT_SYNC_BIT = 0;
  localparam int ACT_HARD_BIT = 1;

  // Revision word; value is arbitrary
  localparam data_t REV_WORD = 16'h0005;

  // Master to slave transfer latency in core cycles
  localparam int UPD_CYC = 4;

  // Indirect address word layout
  localparam logic [4:0] IND_LOCAL_OFS = 5'h00;
  localparam int IND_RD_BIT = 15;
  localparam int IND_PAGE_HI = 9;
  localparam int IND_PAGE_LO = 8;
  localparam int IND_PAGE_WORDS = 256;
  localparam logic [1:0] IND_PAGE_UNUSED = 2'h3;

  // Host end strobe timing in core cycles
  localparam int STROBE_CYC = 8;
  localparam int GAP_CYC = 10;
  localparam int CNT_W = 4;

  // Idle levels of the synchronised control pins {mode, cs_n, wr_n, rd_n}
  localparam logic [3:0] CTRL_IDLE = 4'h7;

endpackage

//--- core/host_port_if.sv
`timescale 1ns/1ps
`default_nettype none

// Parallel host port pins; the shared data bus is resolved here from both enables
interface host_port_if;
  import host_cfg_pkg::*;

  logic cs_n;
  logic wr_n;
  logic rd_n;
  logic rd_mode;
  addr_t addr;
  data_t host_data;
  logic host_oe;
  data_t dev_data;
  logic dev_oe;
  data_t bus;

  // Weak pull-up when nobody drives; device wins a clash, which hides the fault on the bus
  assign bus = dev_oe ? dev_data : (host_oe ? host_data : 16'hFFFF);

  modport device (
    input cs_n,
    input wr_n,
    input rd_n,
    input rd_mode,
    input addr,
    input bus,
    output dev_data,
    output dev_oe
  );

  modport host (
    output cs_n,
    output wr_n,
    output rd_n,
    output rd_mode,
    output addr,
    output host_data,
    output host_oe,
    input bus
  );

endinterface

`default_nettype wire

//--- core/host_port_master.sv
`timescale 1ns/1ps
`default_nettype none

module host_port_master (
  input wire logic core_clk_i,
  input wire logic reset_i,
  host_port_if.host port_if,
  input wire logic read_strobe_mode_select_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire host_cfg_pkg::addr_t req_addr_i,
  input wire host_cfg_pkg::data_t req_data_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output host_cfg_pkg::data_t rsp_data_o
);
  import host_cfg_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SETUP = 5'h02,
    ST_STROBE = 5'h04,
    ST_HOLD = 5'h08,
    ST_GAP = 5'h10
  } host_state_e;

  host_state_e state_q;
  logic [CNT_W-1:0] cnt_q;
  logic write_q;
  logic mode_q;
  logic cs_n_q;
  logic wr_n_q;
  logic rd_n_q;
  logic oe_q;
  addr_t addr_q;
  data_t wdata_q;
  logic ready_q;
  logic rsp_valid_q;
  data_t rsp_data_q;
  data_t bus_s1_q;
  data_t bus_s2_q;

  // Read data arrives from the pins: two flops before use
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      bus_s1_q <= 16'h0000;
      bus_s2_q <= 16'h0000;
    end
    else
    begin
      bus_s1_q <= port_if.bus;
      bus_s2_q <= bus_s1_q;
    end
  end

  // Access sequencer; the long gap covers the device update, so the same
  // address can be reused safely at the cost of throughput
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      write_q <= 1'b0;
      mode_q <= 1'b0;
      cs_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      oe_q <= 1'b0;
      addr_q <= 7'h00;
      wdata_q <= 16'h0000;
      ready_q <= 1'b1;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 16'h0000;
    end
    else
    begin
      rsp_valid_q <= 1'b0;
      unique case (state_q)
        ST_IDLE:
        begin
          if (req_valid_i & ready_q)
          begin
            ready_q <= 1'b0;
            write_q <= req_write_i;
            mode_q <= read_strobe_mode_select_i;
            addr_q <= req_addr_i;
            wdata_q <= req_data_i;
            cs_n_q <= 1'b0;
            oe_q <= req_write_i;
            // Mode one: read pin is the direction, held through the strobe
            rd_n_q <= ~(read_strobe_mode_select_i & ~req_write_i);
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          wr_n_q <= ~(write_q | mode_q);
          rd_n_q <= write_q;
          cnt_q <= CNT_W'(STROBE_CYC - 1);
          state_q <= ST_STROBE;
        end
        ST_STROBE:
        begin
          if (cnt_q == '0)
          begin
            wr_n_q <= 1'b1;
            if (!mode_q)
            begin
              rd_n_q <= 1'b1;
            end
            if (!write_q)
            begin
              rsp_valid_q <= 1'b1;
              rsp_data_q <= bus_s2_q;
            end
            state_q <= ST_HOLD;
          end
          else
          begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ST_HOLD:
        begin
          cs_n_q <= 1'b1;
          rd_n_q <= 1'b1;
          oe_q <= 1'b0;
          cnt_q <= CNT_W'(GAP_CYC - 1);
          state_q <= ST_GAP;
        end
        ST_GAP:
        begin
          if (cnt_q == '0)
          begin
            ready_q <= 1'b1;
            state_q <= ST_IDLE;
          end
          else
          begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
      endcase
    end
  end

  assign port_if.cs_n = cs_n_q;
  assign port_if.wr_n = wr_n_q;
  assign port_if.rd_n = rd_n_q;
  assign port_if.rd_mode = mode_q;
  assign port_if.addr = addr_q;
  assign port_if.host_data = wdata_q;
  assign port_if.host_oe = oe_q;
  assign req_ready_o = ready_q;
  assign rsp_valid_o = rsp_valid_q;
  assign rsp_data_o = rsp_data_q;

endmodule

`default_nettype wire

//--- test/host_port_sva.sv
`timescale 1ns/1ps
`default_nettype none

module host_port_sva (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic rd_mode,
  input wire host_cfg_pkg::addr_t addr,
  input wire host_cfg_pkg::data_t host_data,
  input wire logic host_oe,
  input wire logic dev_oe
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  // Read condition as the pins present it; mode 1 adds the write strobe
  wire rd_c = !cs_n && !rd_n && (!rd_mode || !wr_n);
  // Plain read request at the pins, looked back on by the cause check
  wire rd_pin = !cs_n && !rd_n;

  sequence s_wr_low;
    !wr_n [*8] ##1 wr_n;
  endsequence
  sequence s_oe_gone;
    ##[1:4] !dev_oe;
  endsequence

  property p_oe_cause;
    dev_oe |-> $past(rd_pin, 3);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("bus driven without read");
  property p_oe_on;
    rd_c [*5] |-> dev_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("read not driven");
  property p_oe_off;
    $fell(rd_c) |-> s_oe_gone;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus not released");
  // Both ends on the wire at once would hide a fault behind the resolution
  property p_no_clash;
    !(host_oe && dev_oe);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("bus clash");
  property p_gap;
    $rose(wr_n) |-> wr_n [*4];
  endproperty
  a_gap: assert property (p_gap) else $error("strobe too soon");
  property p_wr_hold;
    !wr_n && !$past(wr_n) && host_oe |-> $stable(addr) && $stable(host_data);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write data moved");
  property p_strobe_cs;
    !wr_n || !rd_n |-> !cs_n;
  endproperty
  a_strobe_cs: assert property (p_strobe_cs) else $error("strobe without select");
  property p_rd_dir;
    rd_mode && !wr_n |-> $stable(rd_n);
  endproperty
  a_rd_dir: assert property (p_rd_dir) else $error("direction moved");
  property p_wr_width;
    $fell(wr_n) |-> s_wr_low;
  endproperty
  a_wr_width: assert property (p_wr_width) else $error("strobe width");
endmodule

`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import host_cfg_pkg::*;
  logic core_clk_i = 0, reset_i = 1, soft_reset_i = 0;
  logic mode = 0, req_valid = 0, req_write = 0;
  addr_t req_addr = '0, cfg_addr;
  data_t req_data = '0, rsp_data, cfg_data, dev_ctrl, out_route;
  logic req_ready, rsp_valid, cfg_upd, sync_out, hard_rst, ind_valid, ind_read;
  logic [1:0] ind_ch, ind_page;
  logic [7:0] ind_word;
  int fails = 0, n_tests = 0;
  int mem [128] = '{default: 0};
  logic [31:0] rng = 32'h80E8;
  addr_t ofs [3] = '{7'h17, 7'h18, 7'h1F};

  host_port_if hp ();
  host_port_master i_host_port_master (.core_clk_i, .reset_i, .port_if(hp),
    .read_strobe_mode_select_i(mode), .req_valid_i(req_valid), .req_write_i(req_write),
    .req_addr_i(req_addr), .req_data_i(req_data), .req_ready_o(req_ready),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data));
  host_port_device i_host_port_device (.core_clk_i, .reset_i, .port_if(hp), .soft_reset_i,
    .cfg_upd_o(cfg_upd), .cfg_addr_o(cfg_addr), .cfg_data_o(cfg_data), .dev_ctrl_o(dev_ctrl),
    .out_route_o(out_route), .sync_out_o(sync_out), .hard_reset_o(hard_rst),
    .ind_valid_o(ind_valid), .ind_read_o(ind_read), .ind_channel_o(ind_ch),
    .ind_page_o(ind_page), .ind_word_o(ind_word));
  host_port_sva i_host_port_sva (.core_clk_i, .reset_i, .cs_n(hp.cs_n), .wr_n(hp.wr_n),
    .rd_n(hp.rd_n), .rd_mode(hp.rd_mode), .addr(hp.addr), .host_data(hp.host_data),
    .host_oe(hp.host_oe), .dev_oe(hp.dev_oe));

  initial
  begin
    forever #(CLK_PERIOD_NS / 2) core_clk_i = ~core_clk_i;
  end

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // Holes and the action word keep no state
  function automatic bit wrable(addr_t a);
    return a[4:3] != REGION_TAIL || a == DEV_CTRL_ADDR || a == DEV_ROUTE_ADDR
      || a == DEV_STATUS_ADDR;
  endfunction

  function automatic data_t rdx(addr_t a);
    if (a == DEV_REV_ADDR)
      return REV_WORD;
    return wrable(a) ? data_t'(mem[a]) : '0;
  endfunction

  task automatic cmp(input data_t got, input data_t exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One access; every pulse in the access window is counted and compared
  task automatic acc(input bit w, input addr_t a, input data_t d, input bit m);
    int k, nu, ni, ns, nh, nr;
    data_t ex;
    bit ind;
    k = 0;
    nu = 0;
    ni = 0;
    ns = 0;
    nh = 0;
    nr = 0;
    ex = rdx(a);
    ind = w && wrable(a) && a[4:0] == IND_LOCAL_OFS && d[9:8] != IND_PAGE_UNUSED;
    while (req_ready !== 1'b1 && k < 50)
    begin
      @(posedge core_clk_i);
      #1;
      k++;
    end
    if (req_ready !== 1'b1)
    begin
      fails++;
      end_of_test();
    end
    {req_valid, req_write, req_addr, req_data, mode} = {1'b1, w, a, d, m};
    @(posedge core_clk_i);
    #1;
    req_valid = 0;
    cmp({15'h0000, req_ready}, 16'h0000);
    repeat (22)
    begin
      @(posedge core_clk_i);
      #1;
      if (cfg_upd === 1'b1)
      begin
        nu++;
        cmp({9'h000, cfg_addr}, {9'h000, a});
        cmp(cfg_data, d);
      end
      if (ind_valid === 1'b1)
      begin
        ni++;
        cmp({3'h0, ind_read, ind_ch, ind_page, ind_word}, {3'h0, d[15], a[6:5], d[9:0]});
      end
      ns += int'(sync_out === 1'b1);
      nh += int'(hard_rst === 1'b1);
      if (rsp_valid === 1'b1)
      begin
        nr++;
        cmp(rsp_data, ex);
      end
    end
    cmp({15'h0000, req_ready}, 16'h0001);
    cmp(data_t'(nu), data_t'(w && wrable(a)));
    cmp(data_t'(ni), data_t'(ind));
    cmp(data_t'(nr), data_t'(!w));
    cmp(data_t'(ns), data_t'(w && a == DEV_ACTION_ADDR && d[ACT_SYNC_BIT]));
    cmp(data_t'(nh), data_t'(w && a == DEV_ACTION_ADDR && d[ACT_HARD_BIT]));
    if (w && wrable(a))
      mem[a] = d;
    if (w && a == DEV_ACTION_ADDR && d[ACT_HARD_BIT])
      mem = '{default: 0};
    cmp(dev_ctrl, data_t'(mem[DEV_CTRL_ADDR]));
    cmp(out_route, data_t'(mem[DEV_ROUTE_ADDR]));
  endtask

  initial
  begin
    logic [31:0] r;
    repeat (6) @(posedge core_clk_i);
    #1;
    reset_i = 0;
    // Device control words, each read back right behind its write
    for (int i = 8'h78; i < 8'h80; i++)
    begin
      r = xs();
      acc(1, addr_t'(i), r[15:0], r[16]);
      acc(0, addr_t'(i), '0, r[17]);
    end
    acc(1, DEV_CTRL_ADDR, 16'hC3A5, 0);
    acc(1, DEV_ACTION_ADDR, 16'h0003, 1);
    acc(0, DEV_CTRL_ADDR, '0, 0);
    // Last word of each channel and both ends of the region tail behind it; for channel 3 that tail is the device control region
    for (int c = 0; c < 4; c++)
    begin
      for (int j = 0; j < 3; j++)
      begin
        r = xs();
        acc(1, {c[1:0], ofs[j][4:0]}, r[15:0], r[16]);
        acc(0, {c[1:0], ofs[j][4:0]}, '0, r[17]);
      end
    end
    // Every channel and page code, with junk in the ignored bits
    for (int i = 0; i < 16; i++)
    begin
      r = xs();
      acc(1, {i[1:0], 5'h00}, {i[0] ^ i[3], r[14:10], i[3:2], r[7:0]}, i[2]);
    end
    // Soft reset clears what reads return
    acc(1, DEV_CTRL_ADDR, 16'h5A3C, 0);
    soft_reset_i = 1;
    @(posedge core_clk_i);
    #1;
    soft_reset_i = 0;
    mem = '{default: 0};
    acc(0, DEV_CTRL_ADDR, '0, 1);
    repeat (40)
    begin
      r = xs();
      acc(r[31], r[6:0], r[23:8], r[30]);
    end
    // Mid-run reset for the full minimum; masters and slaves start from zero
    acc(1, DEV_ROUTE_ADDR, 16'hA55A, 1);
    reset_i = 1;
    repeat (RESET_MIN_CYC) @(posedge core_clk_i);
    #1;
    reset_i = 0;
    mem = '{default: 0};
    acc(0, DEV_ROUTE_ADDR, '0, 0);
    end_of_test();
  end
endmodule

`default_nettype wire
